/* File: design/fdc_codec.sv */
// Format descriptor packet extractor and inserter behind one APB register port.
`timescale 1ns/10ps
module fdc_codec
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic ext_in_valid,
  input wire fdc_pkg::fdc_beat_t ext_in_beat,
  output logic ext_in_ready,
  output logic ext_out_valid,
  output fdc_pkg::fdc_beat_t ext_out_beat,
  input wire logic ext_out_ready,
  input wire logic ins_in_valid,
  input wire fdc_pkg::fdc_beat_t ins_in_beat,
  output logic ins_in_ready,
  output logic ins_out_valid,
  output fdc_pkg::fdc_beat_t ins_out_beat,
  input wire logic ins_out_ready
);
  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic ext_en_q;
  logic ins_en_q;
  logic irq_flag_q;
  logic irq_mask_q;
  logic irq_q;
  logic present_q;
  fdc_pkg::fdc_fmt_t ext_fmt_q;
  fdc_pkg::fdc_fmt_t ins_fmt_q;
  logic ins_present_q;
  logic change_pulse;

  wire [5:0] idx = paddr[7:2];
  wire access = psel & penable & ~pready_q;
  wire wr_done = psel & penable & pready_q & pwrite & ~pslverr_q;
  wire ins_hit = (idx >= fdc_pkg::INS_BASE) && (idx <= fdc_pkg::INS_BASE + fdc_pkg::IDX_PRESENT);
  wire [5:0] ins_idx = idx - fdc_pkg::INS_BASE;
  wire ext_hit = idx <= fdc_pkg::IDX_IRQ_MASK;
  wire mapped = ext_hit | ins_hit;
  wire [31:0] ext_rd =
    (idx == fdc_pkg::IDX_CONTROL) ? {31'h0000_0000, ext_en_q} :
    (idx == fdc_pkg::IDX_IRQ_FLAGS) ? {30'h0000_0000, irq_flag_q, 1'b0} :
    (idx == fdc_pkg::IDX_FORMAT_CODE) ? {28'h000_0000, ext_fmt_q.code} :
    (idx == fdc_pkg::IDX_ASPECT_CODE) ? {31'h0000_0000, ext_fmt_q.aspect} :
    (idx == fdc_pkg::IDX_LBOX_FLAGS) ? {28'h000_0000, ext_fmt_q.flags} :
    (idx == fdc_pkg::IDX_LBOX_FIRST) ? {16'h0000, ext_fmt_q.first} :
    (idx == fdc_pkg::IDX_LBOX_SECOND) ? {16'h0000, ext_fmt_q.second} :
    (idx == fdc_pkg::IDX_PRESENT) ? {31'h0000_0000, present_q} :
    (idx == fdc_pkg::IDX_IRQ_MASK) ? {30'h0000_0000, irq_mask_q, 1'b0} : fdc_pkg::RST_ZERO;
  wire [31:0] ins_rd =
    (ins_idx == fdc_pkg::IDX_CONTROL) ? {31'h0000_0000, ins_en_q} :
    (ins_idx == fdc_pkg::IDX_FORMAT_CODE) ? {28'h000_0000, ins_fmt_q.code} :
    (ins_idx == fdc_pkg::IDX_ASPECT_CODE) ? {31'h0000_0000, ins_fmt_q.aspect} :
    (ins_idx == fdc_pkg::IDX_LBOX_FLAGS) ? {28'h000_0000, ins_fmt_q.flags} :
    (ins_idx == fdc_pkg::IDX_LBOX_FIRST) ? {16'h0000, ins_fmt_q.first} :
    (ins_idx == fdc_pkg::IDX_LBOX_SECOND) ? {16'h0000, ins_fmt_q.second} :
    (ins_idx == fdc_pkg::IDX_PRESENT) ? {31'h0000_0000, ins_present_q} : fdc_pkg::RST_ZERO;
  wire [31:0] rd_mux = ins_hit ? ins_rd : (ext_hit ? ext_rd : fdc_pkg::RST_ZERO);
  wire ext_wr = wr_done & ext_hit;
  wire ins_wr = wr_done & ins_hit;
  wire clr_flag = ext_wr && (idx == fdc_pkg::IDX_IRQ_FLAGS) && pwdata[fdc_pkg::IRQ_CHANGE_BIT];

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= fdc_pkg::RST_ZERO;
    end
    else
    begin
      pready_q <= access;
      pslverr_q <= access & ~mapped;
      prdata_q <= (access & ~pwrite) ? rd_mux : fdc_pkg::RST_ZERO;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_en_q <= 1'b0;
      ins_en_q <= 1'b0;
      irq_mask_q <= 1'b0;
      ins_fmt_q <= '0;
      ins_present_q <= 1'b0;
    end
    else
    begin
      if (ext_wr && idx == fdc_pkg::IDX_CONTROL)
        ext_en_q <= pwdata[fdc_pkg::CTRL_EN_BIT];
      if (ext_wr && idx == fdc_pkg::IDX_IRQ_MASK)
        irq_mask_q <= pwdata[fdc_pkg::IRQ_CHANGE_BIT];
      if (ins_wr && ins_idx == fdc_pkg::IDX_CONTROL)
        ins_en_q <= pwdata[fdc_pkg::CTRL_EN_BIT];
      if (ins_wr && ins_idx == fdc_pkg::IDX_FORMAT_CODE)
        ins_fmt_q.code <= pwdata[3:0];
      if (ins_wr && ins_idx == fdc_pkg::IDX_ASPECT_CODE)
        ins_fmt_q.aspect <= pwdata[0];
      if (ins_wr && ins_idx == fdc_pkg::IDX_LBOX_FLAGS)
        ins_fmt_q.flags <= pwdata[3:0];
      if (ins_wr && ins_idx == fdc_pkg::IDX_LBOX_FIRST)
        ins_fmt_q.first <= pwdata[15:0];
      if (ins_wr && ins_idx == fdc_pkg::IDX_LBOX_SECOND)
        ins_fmt_q.second <= pwdata[15:0];
      if (ins_wr && ins_idx == fdc_pkg::IDX_PRESENT)
        ins_present_q <= pwdata[0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  // A change seen in the same cycle as a clearing write keeps the flag set.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_flag_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_flag_q <= change_pulse | (irq_flag_q & ~clr_flag);
      irq_q <= irq_flag_q & irq_mask_q;
    end
  end

  // ----------------------------------------------------------------
  // Extractor stream
  // ----------------------------------------------------------------
  // Each beat is held in one output register, so the path moves at most one
  // beat every two cycles; this keeps every stream output a flip-flop.
  logic ext_ov_q;
  logic ext_ir_q;
  fdc_pkg::fdc_beat_t ext_ob_q;
  logic ext_keep_q;
  logic ext_anc_q;
  logic [3:0] ext_beat_q;
  logic [7:0] did_q;
  logic [7:0] sdid_q;
  fdc_pkg::fdc_fmt_t shadow_q;
  logic commit_q;
  logic seen_q;

  wire ext_ifire = ext_in_valid & ext_ir_q;
  wire ext_ofire = ext_ov_q & ext_out_ready;
  wire [3:0] ext_type = ext_in_beat.data[3:0];
  wire ext_keep_now = ext_in_beat.sop ? (ext_en_q && ext_type != fdc_pkg::PKT_ANC) : ext_keep_q;
  wire ext_anc_now = ext_in_beat.sop ? (ext_type == fdc_pkg::PKT_ANC) : ext_anc_q;
  wire ext_ov_d = (ext_ifire & ext_keep_now) | (ext_ov_q & ~ext_ofire);
  wire [3:0] ext_beat_d = ext_in_beat.sop ? 4'h1 : ((ext_beat_q == 4'hf) ? ext_beat_q : ext_beat_q + 4'h1);
  wire anc_beat = ext_ifire & ext_anc_now & ~ext_in_beat.sop;
  wire fmt_match = (did_q == fdc_pkg::FMT_DID) && (sdid_q == fdc_pkg::FMT_SDID);
  wire image_sop = ext_ifire & ext_in_beat.sop & (ext_type == fdc_pkg::PKT_VIDEO);
  assign change_pulse = commit_q & fmt_match & (shadow_q != ext_fmt_q);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_ov_q <= 1'b0;
      ext_ir_q <= 1'b0;
      ext_ob_q <= '0;
      ext_keep_q <= 1'b0;
      ext_anc_q <= 1'b0;
      ext_beat_q <= 4'h0;
    end
    else
    begin
      ext_ov_q <= ext_ov_d;
      ext_ir_q <= ~ext_ov_d;
      if (ext_ifire & ext_keep_now)
        ext_ob_q <= ext_in_beat;
      if (ext_ifire)
      begin
        ext_keep_q <= ext_keep_now;
        ext_anc_q <= ext_anc_now;
        ext_beat_q <= ext_beat_d;
      end
    end
  end

  // The ancillary payload is gathered in a shadow copy and only committed
  // after the last beat, so the readable fields never hold a half packet.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      did_q <= 8'h00;
      sdid_q <= 8'h00;
      shadow_q <= '0;
      commit_q <= 1'b0;
      ext_fmt_q <= '0;
      seen_q <= 1'b0;
      present_q <= 1'b0;
    end
    else
    begin
      commit_q <= anc_beat & ext_in_beat.eop;
      if (ext_ifire & ext_in_beat.sop)
      begin
        did_q <= 8'h00;
        sdid_q <= 8'h00;
      end
      // The beat counter already holds the position of the beat being taken.
      if (anc_beat && ext_beat_q == fdc_pkg::BEAT_DID)
        did_q <= ext_in_beat.data[7:0];
      if (anc_beat && ext_beat_q == fdc_pkg::BEAT_SDID)
        sdid_q <= ext_in_beat.data[7:0];
      if (anc_beat && ext_beat_q == fdc_pkg::BEAT_CODES)
      begin
        shadow_q.code <= ext_in_beat.data[3:0];
        shadow_q.aspect <= ext_in_beat.data[4];
      end
      if (anc_beat && ext_beat_q == fdc_pkg::BEAT_FLAGS)
        shadow_q.flags <= ext_in_beat.data[3:0];
      if (anc_beat && ext_beat_q == fdc_pkg::BEAT_FIRST)
        shadow_q.first <= ext_in_beat.data[15:0];
      if (anc_beat && ext_beat_q == fdc_pkg::BEAT_SECOND)
        shadow_q.second <= ext_in_beat.data[15:0];
      // Other ancillary packets leave the decoded fields untouched.
      if (commit_q & fmt_match)
        ext_fmt_q <= shadow_q;
      if (image_sop)
      begin
        present_q <= seen_q | (commit_q & fmt_match);
        seen_q <= 1'b0;
      end
      else if (commit_q & fmt_match)
        seen_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Inserter stream
  // ----------------------------------------------------------------
  fdc_pkg::fdc_ins_state_t ins_st_q;
  fdc_pkg::fdc_ins_state_t ins_st_d;
  logic ins_ov_q;
  logic ins_ir_q;
  fdc_pkg::fdc_beat_t ins_ob_q;
  logic ins_keep_q;
  logic ins_ctrl_q;
  logic [3:0] gen_q;

  wire ins_ifire = ins_in_valid & ins_ir_q;
  wire ins_ofire = ins_ov_q & ins_out_ready;
  wire [3:0] ins_type = ins_in_beat.data[3:0];
  // Incoming ancillary packets are dropped so that only the fresh one goes out.
  wire ins_keep_now = ins_in_beat.sop ? (ins_en_q && ins_type != fdc_pkg::PKT_ANC) : ins_keep_q;
  wire ins_ctrl_now = ins_in_beat.sop ? (ins_type == fdc_pkg::PKT_CTRL) : ins_ctrl_q;
  wire ctrl_end = ins_ifire & ins_keep_now & ins_ctrl_now & ins_in_beat.eop;
  wire gen_load = (ins_st_q == fdc_pkg::INS_GEN) & ~ins_ov_q;
  wire gen_last = gen_q == fdc_pkg::BEAT_SECOND;
  wire ins_ov_d = gen_load | (ins_ifire & ins_keep_now) | (ins_ov_q & ~ins_ofire);
  wire [15:0] gen_data =
    (gen_q == 4'h0) ? {12'h000, fdc_pkg::PKT_ANC} :
    (gen_q == fdc_pkg::BEAT_DID) ? {8'h00, fdc_pkg::FMT_DID} :
    (gen_q == fdc_pkg::BEAT_SDID) ? {8'h00, fdc_pkg::FMT_SDID} :
    (gen_q == fdc_pkg::BEAT_COUNT) ? {8'h00, fdc_pkg::FMT_COUNT} :
    (gen_q == fdc_pkg::BEAT_CODES) ? {11'h000, ins_fmt_q.aspect, ins_fmt_q.code} :
    (gen_q == fdc_pkg::BEAT_FLAGS) ? {12'h000, ins_fmt_q.flags} :
    (gen_q == fdc_pkg::BEAT_FIRST) ? ins_fmt_q.first : ins_fmt_q.second;

  always_comb
  begin
    case (ins_st_q)
      fdc_pkg::INS_FWD: ins_st_d = ctrl_end ? fdc_pkg::INS_GEN : fdc_pkg::INS_FWD;
      fdc_pkg::INS_GEN: ins_st_d = (gen_load & gen_last) ? fdc_pkg::INS_FWD : fdc_pkg::INS_GEN;
      default: ins_st_d = fdc_pkg::INS_FWD;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ins_st_q <= fdc_pkg::INS_FWD;
      ins_ov_q <= 1'b0;
      ins_ir_q <= 1'b0;
      ins_ob_q <= '0;
      ins_keep_q <= 1'b0;
      ins_ctrl_q <= 1'b0;
      gen_q <= 4'h0;
    end
    else
    begin
      ins_st_q <= ins_st_d;
      ins_ov_q <= ins_ov_d;
      ins_ir_q <= (ins_st_d == fdc_pkg::INS_FWD) & ~ins_ov_d;
      if (gen_load)
      begin
        ins_ob_q <= '{sop: gen_q == 4'h0, eop: gen_last, data: gen_data};
        gen_q <= gen_last ? 4'h0 : gen_q + 4'h1;
      end
      else if (ins_ifire & ins_keep_now)
        ins_ob_q <= ins_in_beat;
      if (ins_ifire)
      begin
        ins_keep_q <= ins_keep_now;
        ins_ctrl_q <= ins_ctrl_now;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign ext_in_ready = ext_ir_q;
  assign ext_out_valid = ext_ov_q;
  assign ext_out_beat = ext_ob_q;
  assign ins_in_ready = ins_ir_q;
  assign ins_out_valid = ins_ov_q;
  assign ins_out_beat = ins_ob_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ext_no_anc: assert property (@(posedge ref_clk) disable iff (rst)
    ext_ov_q & ext_ob_q.sop |-> ext_ob_q.data[3:0] != fdc_pkg::PKT_ANC)
    else $error("ancillary packet left the extractor");
  a_ext_off_drop: assert property (@(posedge ref_clk) disable iff (rst)
    ext_ifire & ext_in_beat.sop & ~ext_en_q |=> ~ext_ov_q)
    else $error("disabled extractor forwarded a packet");
  a_ext_commit: assert property (@(posedge ref_clk) disable iff (rst)
    commit_q & fmt_match |=> ext_fmt_q == $past(shadow_q))
    else $error("matching descriptor not committed");
  a_ext_hold: assert property (@(posedge ref_clk) disable iff (rst)
    ~(commit_q & fmt_match) |=> $stable(ext_fmt_q))
    else $error("decoded fields changed without a matching packet");
  a_irq_change: assert property (@(posedge ref_clk) disable iff (rst)
    change_pulse |=> irq_flag_q ##1 (irq_flag_q | $past(clr_flag)))
    else $error("change flag not raised");
  a_read_code: assert property (@(posedge ref_clk) disable iff (rst)
    access & ~pwrite & (idx == fdc_pkg::IDX_FORMAT_CODE) |=> prdata_q[3:0] == $past(ext_fmt_q.code))
    else $error("format code read wrong");
  a_read_aspect: assert property (@(posedge ref_clk) disable iff (rst)
    access & ~pwrite & (idx == fdc_pkg::IDX_ASPECT_CODE) |=> prdata_q == {31'h0000_0000, $past(ext_fmt_q.aspect)})
    else $error("aspect code read wrong");
  a_ins_after_ctrl: assert property (@(posedge ref_clk) disable iff (rst)
    ctrl_end |=> ins_st_q == fdc_pkg::INS_GEN ##[1:20] (ins_ov_q & ins_ob_q.sop & ins_ob_q.data[3:0] == fdc_pkg::PKT_ANC))
    else $error("no ancillary packet after control packet");
  a_ins_ident: assert property (@(posedge ref_clk) disable iff (rst)
    gen_load & (gen_q == fdc_pkg::BEAT_SDID) |=> ins_ob_q.data[7:0] == fdc_pkg::FMT_SDID)
    else $error("inserted secondary identifier wrong");
endmodule

/* File: pkg/fdc_pkg.sv */
// Constants and types shared by the format descriptor packet codec.
package fdc_pkg;
  localparam int DATA_W = 16;
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_CONTROL = 6'h00;
  localparam logic [5:0] IDX_RSVD_ONE = 6'h01;
  localparam logic [5:0] IDX_IRQ_FLAGS = 6'h02;
  localparam logic [5:0] IDX_FORMAT_CODE = 6'h03;
  localparam logic [5:0] IDX_ASPECT_CODE = 6'h04;
  localparam logic [5:0] IDX_LBOX_FLAGS = 6'h05;
  localparam logic [5:0] IDX_LBOX_FIRST = 6'h06;
  localparam logic [5:0] IDX_LBOX_SECOND = 6'h07;
  localparam logic [5:0] IDX_PRESENT = 6'h08;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h09;
  localparam logic [5:0] INS_BASE = 6'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam int IRQ_CHANGE_BIT = 1;
  // Packet type carried in bits 3:0 of the first beat.
  localparam logic [3:0] PKT_VIDEO = 4'h0;
  localparam logic [3:0] PKT_ANC = 4'hd;
  localparam logic [3:0] PKT_CTRL = 4'hf;
  localparam logic [7:0] FMT_DID = 8'h41;
  localparam logic [7:0] FMT_SDID = 8'h05;
  localparam logic [7:0] FMT_COUNT = 8'h04;
  // Beat positions inside an ancillary packet, counted from the type beat.
  localparam logic [3:0] BEAT_DID = 4'h1;
  localparam logic [3:0] BEAT_SDID = 4'h2;
  localparam logic [3:0] BEAT_COUNT = 4'h3;
  localparam logic [3:0] BEAT_CODES = 4'h4;
  localparam logic [3:0] BEAT_FLAGS = 4'h5;
  localparam logic [3:0] BEAT_FIRST = 4'h6;
  localparam logic [3:0] BEAT_SECOND = 4'h7;
  localparam logic [3:0] CODE_LBOX_A = 4'b0000;
  localparam logic [3:0] CODE_LBOX_B = 4'b0100;
  localparam logic [3:0] CODE_PILLAR = 4'b0011;
  localparam logic [3:0] CODE_TOPBOT = 4'b1100;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic sop;
    logic eop;
    logic [DATA_W-1:0] data;
  } fdc_beat_t;

  // Decoded contents of one format description packet.
  typedef struct packed {
    logic [3:0] code;
    logic aspect;
    logic [3:0] flags;
    logic [15:0] first;
    logic [15:0] second;
  } fdc_fmt_t;

  typedef enum logic [1:0] {
    INS_FWD = 2'b01,
    INS_GEN = 2'b10
  } fdc_ins_state_t;
endpackage

/* File: tb/fdc_stream_partner.sv */
// Stream source and stalling sink that stand on both sides of one codec path.
`timescale 1ns/10ps
module fdc_stream_partner
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  output logic src_valid,
  output fdc_pkg::fdc_beat_t src_beat,
  input wire logic src_ready,
  input wire logic snk_valid,
  input wire fdc_pkg::fdc_beat_t snk_beat,
  output logic snk_ready
);
  fdc_pkg::fdc_beat_t tx_q[$];
  fdc_pkg::fdc_beat_t rx_q[$];

  // A beat is held until it is taken; an idle line inverts its last value every cycle.
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      src_valid <= 1'b0;
      src_beat <= '0;
      snk_ready <= 1'b0;
    end
    else
    begin
      if (!src_valid || src_ready)
      begin
        if (tx_q.size() > 0)
        begin
          src_valid <= 1'b1;
          src_beat <= tx_q.pop_front();
        end
        else
        begin
          src_valid <= 1'b0;
          src_beat <= ~src_beat;
        end
      end
      if (snk_valid && snk_ready)
        rx_q.push_back(snk_beat);
      snk_ready <= slow ? ~snk_ready : 1'b1;
    end
  end
endmodule

/* File: tb/fdc_codec_tb.sv */
// Self-checking bench for the format descriptor packet codec.
`timescale 1ns/10ps
module fdc_codec_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, err;
  logic ev, er, eov, eor, iv, ir, iov, ior;
  fdc_pkg::fdc_beat_t eb, eob, ib, iob;
  fdc_pkg::fdc_beat_t exp_q[2][$];
  logic [15:0] wq[$];
  logic [3:0] codes[3] = '{4'b0000, 4'b0100, 4'b1100};
  logic [31:0] wv[9] = '{32'h1, 32'hffff, 32'hffff, 32'hc, 32'h1, 32'ha, 32'haa, 32'hbb0, 32'h1};
  int miscompares = 0;
  int num_checks = 0;

  fdc_codec i_fdc_codec(.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .ext_in_valid(ev), .ext_in_beat(eb), .ext_in_ready(er), .ext_out_valid(eov), .ext_out_beat(eob),
    .ext_out_ready(eor), .ins_in_valid(iv), .ins_in_beat(ib), .ins_in_ready(ir), .ins_out_valid(iov),
    .ins_out_beat(iob), .ins_out_ready(ior));
  fdc_stream_partner i_fdc_stream_partner_e(.ref_clk(ref_clk), .rst(rst), .slow(1'b1), .src_valid(ev),
    .src_beat(eb), .src_ready(er), .snk_valid(eov), .snk_beat(eob), .snk_ready(eor));
  fdc_stream_partner i_fdc_stream_partner_i(.ref_clk(ref_clk), .rst(rst), .slow(1'b1), .src_valid(iv),
    .src_beat(ib), .src_ready(ir), .snk_valid(iov), .snk_beat(iob), .snk_ready(ior));

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Bus and stream tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The master holds the request until pready is seen high, for at most 50 cycles.
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Pready, read data and error are taken at the rising edge that sees pready high.
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50)
      chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic put(input bit ins, input bit fwd, input bit snd);
    fdc_pkg::fdc_beat_t b;
    for (int k = 0; k < wq.size(); k++)
    begin
      b.sop = (k == 0);
      b.eop = (k == wq.size() - 1);
      b.data = wq[k];
      if (fwd)
        exp_q[ins].push_back(b);
      if (snd && ins)
        i_fdc_stream_partner_i.tx_q.push_back(b);
      if (snd && !ins)
        i_fdc_stream_partner_e.tx_q.push_back(b);
    end
  endtask

  task automatic anc(input logic [7:0] did, input logic [3:0] code, input logic asp, input logic [3:0] fl,
    input logic [15:0] v1, input logic [15:0] v2);
    wq = '{16'h000d, {8'h00, did}, 16'h0005, 16'h0004, {11'h0, asp, code}, {12'h0, fl}, v1, v2};
    put(1'b0, 1'b0, 1'b1);
    wq = '{16'h0000, 16'habcd};
    put(1'b0, 1'b1, 1'b1);
  endtask

  // A short quiet spell after the expected count catches surplus beats.
  task automatic drain(input bit ins);
    fdc_pkg::fdc_beat_t got[$];
    int n;
    n = 0;
    got = ins ? i_fdc_stream_partner_i.rx_q : i_fdc_stream_partner_e.rx_q;
    while (n < 400 && got.size() < exp_q[ins].size())
    begin
      @(posedge ref_clk);
      got = ins ? i_fdc_stream_partner_i.rx_q : i_fdc_stream_partner_e.rx_q;
      n++;
    end
    repeat (20) @(posedge ref_clk);
    got = ins ? i_fdc_stream_partner_i.rx_q : i_fdc_stream_partner_e.rx_q;
    chk(got.size(), exp_q[ins].size());
    for (int k = 0; k < exp_q[ins].size() && k < got.size(); k++)
      chk(32'(got[k]), 32'(exp_q[ins][k]));
    exp_q[ins].delete();
    i_fdc_stream_partner_i.rx_q.delete();
    i_fdc_stream_partner_e.rx_q.delete();
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    #500_000;
    miscompares++;
    conclude();
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(fdc_pkg::IDX_CONTROL, 32'h0);
    rdc(fdc_pkg::IDX_IRQ_FLAGS, 32'h0);
    rdc(fdc_pkg::IDX_PRESENT, 32'h0);
    apb(1'b1, fdc_pkg::IDX_RSVD_ONE, 32'hffff_ffff);
    rdc(fdc_pkg::IDX_RSVD_ONE, 32'h0);
    apb(1'b0, 6'h0a, 32'h0000_0000);
    chk(err, 1'b1);
    wq = '{16'h0000, 16'h0111, 16'h0222};
    put(1'b0, 1'b0, 1'b1);
    put(1'b1, 1'b0, 1'b1);
    drain(1'b0);
    drain(1'b1);
    apb(1'b1, fdc_pkg::IDX_CONTROL, 32'h1);
    apb(1'b1, fdc_pkg::IDX_IRQ_MASK, 32'h2);
    wq = '{16'h000f, 16'h0780};
    put(1'b0, 1'b1, 1'b1);
    anc(8'h41, 4'b0011, 1'b1, 4'h5, 16'h1234, 16'h5678);
    drain(1'b0);
    rdc(fdc_pkg::IDX_FORMAT_CODE, 32'h3);
    rdc(fdc_pkg::IDX_ASPECT_CODE, 32'h1);
    rdc(fdc_pkg::IDX_LBOX_FLAGS, 32'h5);
    rdc(fdc_pkg::IDX_LBOX_FIRST, 32'h1234);
    rdc(fdc_pkg::IDX_LBOX_SECOND, 32'h5678);
    rdc(fdc_pkg::IDX_PRESENT, 32'h1);
    rdc(fdc_pkg::IDX_IRQ_FLAGS, 32'h2);
    chk(irq, 1'b1);
    apb(1'b1, fdc_pkg::IDX_IRQ_FLAGS, 32'h2);
    rdc(fdc_pkg::IDX_IRQ_FLAGS, 32'h0);
    chk(irq, 1'b0);
    anc(8'h42, 4'h8, 1'b0, 4'hf, 16'hffff, 16'hffff);
    drain(1'b0);
    rdc(fdc_pkg::IDX_FORMAT_CODE, 32'h3);
    rdc(fdc_pkg::IDX_LBOX_FIRST, 32'h1234);
    rdc(fdc_pkg::IDX_IRQ_FLAGS, 32'h0);
    rdc(fdc_pkg::IDX_PRESENT, 32'h0);
    for (int k = 0; k < 3; k++)
    begin
      anc(8'h41, codes[k], k[0], 4'(k + 8), 16'(k + 256), 16'(k + 512));
      drain(1'b0);
      rdc(fdc_pkg::IDX_FORMAT_CODE, 32'(codes[k]));
      rdc(fdc_pkg::IDX_ASPECT_CODE, 32'(k[0]));
      rdc(fdc_pkg::IDX_LBOX_FLAGS, 32'(k + 8));
      rdc(fdc_pkg::IDX_LBOX_FIRST, 32'(k + 256));
      rdc(fdc_pkg::IDX_LBOX_SECOND, 32'(k + 512));
      rdc(fdc_pkg::IDX_IRQ_FLAGS, 32'h2);
      apb(1'b1, fdc_pkg::IDX_IRQ_FLAGS, 32'h2);
    end
    for (int n = 0; n < 9; n++)
      apb(1'b1, fdc_pkg::INS_BASE + 6'(n), wv[n]);
    for (int n = 0; n < 9; n++)
      rdc(fdc_pkg::INS_BASE + 6'(n), (n == 1 || n == 2) ? 32'h0 : wv[n]);
    for (int k = 0; k < 2; k++)
    begin
      wq = '{16'h000f, 16'h0780};
      put(1'b1, 1'b1, 1'b1);
      wq = '{16'h000d, 16'h0041, 16'h0005, 16'h0004, 16'h001c, 16'h000a, 16'h00aa, 16'h0bb0};
      put(1'b1, 1'b1, 1'b0);
    end
    wq = '{16'h0000, 16'h0123};
    put(1'b1, 1'b1, 1'b1);
    drain(1'b1);
    conclude();
  end
endmodule
